// *** design/caf_axil_slave.sv ***
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the register core decodes combinationally on the same clock.
`timescale 1ns/1ns
module caf_axil_slave
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  caf_regbus_if.bus rb
);
  import caf_pkg::*;
  `include "caf_regs.svh"

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rd_pend;
    logic [7:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } caf_axs_t;

  caf_axs_t q;
  caf_axs_t d;
  logic wr_fire;

  // Address and data may arrive in either order; commit once both held
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign rb.wr_en = wr_fire;
  assign rb.wr_addr = q.awaddr;
  assign rb.wr_data = q.wdata;
  assign rb.wr_strb = q.wstrb;
  assign rb.rd_addr = q.araddr;

  // Channel handshakes and response generation
  always_comb
  begin
    d = q;
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = rb.wr_ok ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
    end
    else if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    // Readies are registered, so they drop the cycle after a capture
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    if (s_axi_arvalid && q.arready)
    begin
      d.rd_pend = 1'b1;
      d.araddr = s_axi_araddr;
    end
    if (q.rd_pend && !q.rvalid)
    begin
      d.rd_pend = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rb.rd_data;
      d.rresp = rb.rd_ok ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
    end
    else if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    d.arready = !d.rd_pend && !d.rvalid;
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule

// *** design/caf_filter_cfg.sv ***
// Acceptance filter configuration for filters 20 to 23 of a CAN receiver,
// with masks, filter identifiers and the frame routing decision.
// Assumes an AXI4-Lite master on ref_clk and receive logic that strobes
// each received identifier for one ref_clk cycle.
// Summary of operation
// RULE1 - Each filter has an on bit; off filters never match.
// RULE2 - Two-bit mask choice picks acceptance mask 0 to 3.
// RULE3 - Five-bit FIFO choice names the FIFO 0 to 31 for matches.
// RULE4 - Mask and FIFO choices change only while the filter is off.
// RULE5 - Filter control bank five holds filters 20 to 23 fields.
// RULE6 - Enabled filters compare ID under mask and route frames to FIFO.
`timescale 1ns/1ns
module caf_filter_cfg
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_valid,
  input wire caf_pkg::caf_id_t frame_id,
  output logic route_valid,
  output logic [4:0] route_filter,
  output logic [4:0] route_fifo,
  output logic [1:0] route_mask
);
  import caf_pkg::*;
  `include "caf_regs.svh"

  typedef struct packed {
    caf_bank_t bank;
    caf_idarr_t mask;
    caf_idarr_t fid;
  } caf_core_t;

  caf_core_t q;
  caf_core_t d;
  logic [15:0] hit_count;

  caf_regbus_if rb ();
  caf_cfg_if cfg ();

  caf_axil_slave u_slave
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.bus)
  );

  caf_match u_match
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg(cfg.sink),
    .frame_valid(frame_valid),
    .frame_id(frame_id),
    .route_valid(route_valid),
    .route_filter(route_filter),
    .route_fifo(route_fifo),
    .route_mask(route_mask),
    .hit_count(hit_count)
  );

  // Live configuration seen by the matcher
  assign cfg.bank = q.bank;
  assign cfg.mask = q.mask;
  assign cfg.fid = q.fid;

  // Register writes and read decode
  always_comb
  begin
    logic [7:0] grp;
    logic [7:0] lane;
    logic [1:0] idx;
    logic wgrp_ok;
    logic rgrp_ok;
    grp = rb.wr_addr & `CAF_OFF_GROUP_MASK;
    idx = rb.wr_addr[3:2];
    lane = 8'h00;
    wgrp_ok = 1'b0;
    rgrp_ok = 1'b0;
    d = q;
    wgrp_ok = (rb.wr_addr[1:0] == 2'h0) &&
      ((rb.wr_addr == `CAF_OFF_FLTCTL5) ||
      (grp == `CAF_OFF_MASK_BASE) || (grp == `CAF_OFF_FID_BASE) ||
      (rb.wr_addr == `CAF_OFF_STATUS));
    rb.wr_ok = wgrp_ok;
    if (rb.wr_en && (rb.wr_addr == `CAF_OFF_FLTCTL5))
    begin
      // One byte lane per filter; lanes 0 and 1 carry filters 20, 21
      for (int i = 0; i < 4; i++)
        if (rb.wr_strb[i])
        begin
          lane = rb.wr_data[8*i +: 8];
          d.bank[i].on = lane[`CAF_ON_BIT]; // RULE1 RULE5
          // Choices are frozen while this filter is on; the on bit
          // itself still writes so software can turn it off first
          if (!q.bank[i].on) // RULE4
          begin
            d.bank[i].mask_choice = lane[`CAF_MSEL_LSB +: 2]; // RULE2
            d.bank[i].fifo_choice = lane[`CAF_FSEL_LSB +: 5]; // RULE3
          end
        end
    end
    // Unaligned hits inside a group answer SLVERR and must not write
    else if (rb.wr_en && wgrp_ok && (grp == `CAF_OFF_MASK_BASE))
    begin
      if (rb.wr_strb[0])
        d.mask[idx][7:0] = rb.wr_data[7:0];
      if (rb.wr_strb[1])
        d.mask[idx][10:8] = rb.wr_data[10:8];
    end
    else if (rb.wr_en && wgrp_ok && (grp == `CAF_OFF_FID_BASE))
    begin
      if (rb.wr_strb[0])
        d.fid[idx][7:0] = rb.wr_data[7:0];
      if (rb.wr_strb[1])
        d.fid[idx][10:8] = rb.wr_data[10:8];
    end
    // Read side; status is read only and ignores writes
    grp = rb.rd_addr & `CAF_OFF_GROUP_MASK;
    idx = rb.rd_addr[3:2];
    rgrp_ok = (rb.rd_addr[1:0] == 2'h0);
    rb.rd_data = 32'h00000000;
    rb.rd_ok = 1'b0;
    if (rgrp_ok && (rb.rd_addr == `CAF_OFF_FLTCTL5))
    begin
      rb.rd_data = q.bank;
      rb.rd_ok = 1'b1;
    end
    else if (rgrp_ok && (grp == `CAF_OFF_MASK_BASE))
    begin
      rb.rd_data = {21'h000000, q.mask[idx]};
      rb.rd_ok = 1'b1;
    end
    else if (rgrp_ok && (grp == `CAF_OFF_FID_BASE))
    begin
      rb.rd_data = {21'h000000, q.fid[idx]};
      rb.rd_ok = 1'b1;
    end
    else if (rgrp_ok && (rb.rd_addr == `CAF_OFF_STATUS))
    begin
      rb.rd_data = {hit_count, 4'h0, route_mask, route_fifo, route_filter};
      rb.rd_ok = 1'b1;
    end
  end

  // Configuration register; everything off and zero after reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q.bank <= `CAF_BANK_RST;
      q.mask <= '0;
      q.fid <= '0;
    end
    else
      q <= d;
  end
endmodule

// *** design/caf_match.sv ***
// Acceptance matcher for filters 20 to 23 and the routing decision.
// Assumes frame strobes come from receive logic on ref_clk.
`timescale 1ns/1ns
module caf_match
(
  input wire logic ref_clk,
  input wire logic rst,
  caf_cfg_if.sink cfg,
  input wire logic frame_valid,
  input wire caf_pkg::caf_id_t frame_id,
  output logic route_valid,
  output logic [4:0] route_filter,
  output logic [4:0] route_fifo,
  output logic [1:0] route_mask,
  output logic [15:0] hit_count
);
  import caf_pkg::*;
  `include "caf_regs.svh"

  typedef struct packed {
    logic valid;
    logic [4:0] filt;
    logic [4:0] fifo;
    logic [1:0] mask;
    logic [15:0] count;
  } caf_mst_t;

  caf_mst_t q;
  caf_mst_t d;
  logic [3:0] hit;

  // Per filter compare under its chosen mask; a 1 in a mask bit compares
  for (genvar i = 0; i < 4; i++)
  begin : g_cmp
    assign hit[i] = cfg.bank[i].on && // RULE1
      (((frame_id ^ cfg.fid[i]) &
      cfg.mask[cfg.bank[i].mask_choice]) == `CAF_ID_RST); // RULE2 RULE6
  end

  // Lowest numbered matching filter wins, one route per frame
  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    if (frame_valid && (hit != 4'h0))
    begin
      d.valid = 1'b1;
      d.count = q.count + 16'h0001;
      for (int i = 3; i >= 0; i--)
        if (hit[i])
        begin
          d.filt = `CAF_FLT_FIRST + 5'(i);
          d.fifo = cfg.bank[i].fifo_choice; // RULE3 RULE6
          d.mask = cfg.bank[i].mask_choice;
        end
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign route_valid = q.valid;
  assign route_filter = q.filt;
  assign route_fifo = q.fifo;
  assign route_mask = q.mask;
  assign hit_count = q.count;
endmodule

// *** include/caf_ifs.sv ***
// Interfaces between the register slave, the register core and matcher.
// Assumes everything runs on ref_clk.
`timescale 1ns/1ns
interface caf_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface

interface caf_cfg_if;
  caf_pkg::caf_bank_t bank;
  caf_pkg::caf_idarr_t mask;
  caf_pkg::caf_idarr_t fid;
  modport src (output bank, mask, fid);
  modport sink (input bank, mask, fid);
endinterface

// *** include/caf_pkg.sv ***
// Types shared by the acceptance filter configuration block.
// Assumes standard 11-bit CAN identifiers.
package caf_pkg;
  typedef logic [10:0] caf_id_t;
  // One byte per filter: on at bit 7, mask choice 6:5, FIFO choice 4:0
  typedef struct packed {
    logic on;
    logic [1:0] mask_choice;
    logic [4:0] fifo_choice;
  } caf_filt_t;
  typedef caf_filt_t [3:0] caf_bank_t;
  typedef caf_id_t [3:0] caf_idarr_t;
endpackage

// *** include/caf_regs.svh ***
// Register offsets, reset values and field layout of the filter block.
// Assumes 32-bit AXI4-Lite words; offsets are byte addresses.
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH
`define CAF_OFF_FLTCTL5 8'h00
`define CAF_OFF_MASK_BASE 8'h10
`define CAF_OFF_FID_BASE 8'h20
`define CAF_OFF_STATUS 8'h30
`define CAF_OFF_GROUP_MASK 8'hF0
`define CAF_FLT_FIRST 5'h14
`define CAF_ON_BIT 7
`define CAF_MSEL_LSB 5
`define CAF_FSEL_LSB 0
`define CAF_BANK_RST 32'h00000000
`define CAF_ID_RST 11'h000
`define CAF_RESP_OKAY 2'h0
`define CAF_RESP_SLVERR 2'h2
`endif

// *** sim/caf_filter_cfg_tb_top.sv ***
// Self-checking bench for the acceptance filter configuration block.
// Assumes an AXI4-Lite master here and the receive model beside it.
`timescale 1ns/1ns
module caf_filter_cfg_tb_top;
  import caf_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, frame_valid, route_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] route_filter, route_fifo;
  logic [1:0] route_mask;
  caf_id_t frame_id;
  int n_mismatch = 0, n_tests = 0;

  caf_filter_cfg u_dut (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .frame_valid(frame_valid),
    .frame_id(frame_id), .route_valid(route_valid),
    .route_filter(route_filter), .route_fifo(route_fifo),
    .route_mask(route_mask));
  caf_rx_model u_rx (.ref_clk(ref_clk), .frame_valid(frame_valid),
    .frame_id(frame_id));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait guard shared by both bus tasks
  task automatic guard(input int n);
    if (n > 50)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ex);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // Strobe one id and look at the route one cycle later
  task automatic fr(input logic [10:0] id, input logic v,
    input logic [4:0] f, input logic [4:0] fi, input logic [1:0] m);
    u_rx.send(id);
    #1;
    chk("route_valid", {31'h0, route_valid}, {31'h0, v});
    if (v)
      chk("route", {20'h0, route_filter, route_fifo, route_mask},
        {20'h0, f, fi, m});
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    axr(8'h00, 32'h0, 2'h0);
    axw(8'h10, 32'h7FF, 2'h0);
    axw(8'h14, 32'h7FF, 2'h0);
    axw(8'h18, 32'h7FF, 2'h0);
    axw(8'h1C, 32'h700, 2'h0);
    axw(8'h20, 32'h123, 2'h0);
    axw(8'h24, 32'h5A5, 2'h0);
    axw(8'h00, 32'h0000001F, 2'h0);
    fr(11'h123, 1'b0, 5'h0, 5'h0, 2'h0);
    // Every mask choice, each programmed with the filter off first
    for (int m = 0; m < 4; m++)
    begin
      axw(8'h00, 32'h0, 2'h0);
      axw(8'h00, {24'h0, 1'b1, 2'(m), 5'(m + 28)}, 2'h0);
      fr(11'h123, 1'b1, 5'h14, 5'(m + 28), 2'(m));
    end
    axw(8'h00, 32'h0, 2'h0);
    axw(8'h00, 32'h0000E09F, 2'h0);
    axr(8'h00, 32'h0000E09F, 2'h0);
    fr(11'h123, 1'b1, 5'h14, 5'h1F, 2'h0);
    fr(11'h5FF, 1'b1, 5'h15, 5'h00, 2'h3);
    fr(11'h0F0, 1'b0, 5'h0, 5'h0, 2'h0);
    // Choices are frozen while on; the on bit still writes
    axw(8'h00, 32'h0000C081, 2'h0);
    axr(8'h00, 32'h0000E09F, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
    axr(8'h00, 32'h0000601F, 2'h0);
    axw(8'h00, 32'h000020A2, 2'h0);
    axr(8'h00, 32'h000020A2, 2'h0);
    fr(11'h123, 1'b1, 5'h14, 5'h02, 2'h1);
    // Status: seven matches so far, last one filter 20, FIFO 2, mask 1
    axr(8'h30, 32'h00070454, 2'h0);
    axw(8'h30, 32'hFFFFFFFF, 2'h0);
    axr(8'h30, 32'h00070454, 2'h0);
    // Unaligned access is refused and leaves the mask alone
    axw(8'h12, 32'h0, 2'h2);
    axr(8'h10, 32'h000007FF, 2'h0);
    axr(8'h12, 32'h0, 2'h2);
    axr(8'h1C, 32'h00000700, 2'h0);
    axr(8'h24, 32'h000005A5, 2'h0);
    axw(8'h40, 32'hFFFFFFFF, 2'h2);
    axr(8'h40, 32'h0, 2'h2);
    report_and_stop();
  end
endmodule

// *** sim/caf_rx_model.sv ***
// Receive side stand-in: strobes one received identifier per call.
// Assumes callers are synced to ref_clk.
`timescale 1ns/1ns
module caf_rx_model
(
  input wire logic ref_clk,
  output logic frame_valid,
  output caf_pkg::caf_id_t frame_id
);
  import caf_pkg::*;
  initial
  begin
    frame_valid = 1'b0;
    frame_id = 11'h2AA;
  end
  // Idle id is inverted so a stale value never passes as fresh
  task automatic send(input caf_id_t id);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    frame_id <= id;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    frame_id <= ~id;
  endtask
endmodule

// *** sim/caf_sva.sv ***
// Port checker for the acceptance filter configuration block.
// Assumes it is bound to caf_filter_cfg; one clock, sync reset.
`timescale 1ns/1ns
module caf_sva
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_valid,
  input wire logic route_valid,
  input wire logic [4:0] route_filter,
  input wire logic [4:0] route_fifo,
  input wire logic [1:0] route_mask,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Routes need a frame strobe one cycle earlier
  route_cause_a: assert property (
    route_valid |-> $past(frame_valid))
    else $error("route without a frame");
  // Only filters 20 to 23 live in this block
  route_range_a: assert property (
    route_valid |-> route_filter inside {[5'h14:5'h17]})
    else $error("route names a foreign filter");
  // Held fields may only move with a route pulse
  route_hold_a: assert property (
    !route_valid |-> $stable({route_filter, route_fifo, route_mask}))
    else $error("route fields moved without a match");
  route_pulse_a: assert property (
    route_valid && !frame_valid |=> !route_valid)
    else $error("route pulse too long");
  // Address is registered first, so the answer shows two edges after the handshake
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
    else $error("read answer late");
  write_code_a: assert property (
    s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
endmodule

bind caf_filter_cfg caf_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .frame_valid(frame_valid), .route_valid(route_valid),
  .route_filter(route_filter), .route_fifo(route_fifo),
  .route_mask(route_mask), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp));
